// File: hw/spiev_pkg.sv
package spiev_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS    = 8;
    localparam int         SCK_HALF_NS      = 40;
    localparam int         SCK_HALF_ALT_NS  = 80;
    // half bit period in system clock cycles, rounded down, no lower limit
    localparam logic [3:0] SCK_HALF_CYC     = 4'(SCK_HALF_NS / CLK_PERIOD_NS);
    localparam logic [3:0] SCK_HALF_ALT_CYC = 4'(SCK_HALF_ALT_NS / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // register map (word index on the register port)
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_CTRL1L  = 3'h0;
    localparam logic [2:0] REG_CTRL1H  = 3'h1;
    localparam logic [2:0] REG_CTRL2L  = 3'h2;
    localparam logic [2:0] REG_STATUS  = 3'h3;
    localparam logic [2:0] REG_IMSKL   = 3'h4;
    localparam logic [2:0] REG_DATA_LO = 3'h5;
    localparam logic [2:0] REG_DATA_HI = 3'h6;

    // control 1 low fields
    localparam int BIT_PORT_ON   = 15;
    localparam int BIT_STOP_IDLE = 13;
    localparam int BIT_SDO_DIS   = 12;
    localparam int BIT_WORD32    = 11;
    localparam int BIT_WORD16    = 10;
    localparam int BIT_SMP       = 9;
    localparam int BIT_CKE       = 8;
    localparam int BIT_SLAVE_SELECT_ENABLE      = 7;
    localparam int BIT_CKP       = 6;
    localparam int BIT_MASTER    = 5;
    localparam int BIT_MCLK_SEL  = 2;
    // control 1 high fields
    localparam int BIT_AUDIO_MODE_ENABLE     = 15;
    localparam int BIT_FRAMED_MODE_ENABLE     = 14;
    localparam int BIT_FSPW      = 11;
    localparam int BIT_DSP_MODE  = 0;

    localparam logic [15:0] CTRL1L_WMASK = 16'hBFFF;
    localparam logic [15:0] CTRL1H_WMASK = 16'hC801;
    localparam logic [15:0] CTRL2L_WMASK = 16'h001F;
    localparam logic [15:0] MCLK_MASK    = 16'h0004;
    localparam logic [15:0] RESET_VALUE  = 16'h0000;

    // event bits, shared by status and event enable registers
    localparam int EV_FRMERR = 12;
    localparam int EV_BUSY   = 11;
    localparam int EV_TUR    = 8;
    localparam int EV_SRMT   = 7;
    localparam int EV_ROV    = 6;
    localparam int EV_RBE    = 5;
    localparam int EV_TBE    = 3;
    localparam int EV_TBF    = 1;
    localparam int EV_RBF    = 0;
    localparam logic [15:0] EVT_MASK = 16'h19EB;

    // word lengths
    localparam logic [5:0] LEN_8  = 6'h08;
    localparam logic [5:0] LEN_16 = 6'h10;
    localparam logic [5:0] LEN_24 = 6'h18;
    localparam logic [5:0] LEN_32 = 6'h20;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } spiev_state_t;

    function automatic logic [5:0] spiev_data_bits(input logic aud, input logic m32, input logic m16,
                                                   input logic [4:0] wlen);
        logic [5:0] n;
        n = LEN_8;
        if (aud)
            n = m32 ? (m16 ? LEN_24 : LEN_32) : LEN_16;
        else if (wlen != 5'h00)
            n = {1'b0, wlen} + 6'h01;
        else
            n = m32 ? LEN_32 : (m16 ? LEN_16 : LEN_8);
        return n;
    endfunction : spiev_data_bits

    function automatic logic [5:0] spiev_chan_bits(input logic aud, input logic m32, input logic m16,
                                                   input logic [5:0] dataBits);
        logic [5:0] n;
        n = dataBits;
        if (aud)
            n = (m32 | m16) ? LEN_32 : LEN_16;
        return n;
    endfunction : spiev_chan_bits

    function automatic logic [31:0] spiev_low_mask(input logic [5:0] n);
        logic [31:0] m;
        m = (n >= LEN_32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
        return m;
    endfunction : spiev_low_mask

endpackage : spiev_pkg

// File: hw/spiev_sync.sv
`timescale 1ns/1ps
module spiev_sync
    import spiev_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output wire logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;

    // first stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_r   <= '0;
            stable_r <= '0;
        end
        else
        begin
            meta_r   <= d;
            stable_r <= meta_r;
        end
    end

    assign q = stable_r;

endmodule : spiev_sync

// File: hw/spiev_port.sv
`timescale 1ns/1ps
module spiev_port
    import spiev_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        cpuIdle,
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output wire logic [15:0] regRdata,
    input  wire logic        sckIn,
    output wire logic        sckOut,
    output wire logic        sckOe,
    input  wire logic        sdiIn,
    output wire logic        sdoOut,
    output wire logic        sdoOe,
    input  wire logic        slaveSel_n,
    output wire logic        lrcOut,
    output wire logic        lrcOe,
    output wire logic        irq
);

    // ----------------------------------------------------------------
    // registers and decode
    // ----------------------------------------------------------------
    logic [15:0]  ctrl1L_r;
    logic [15:0]  ctrl1H_r;
    logic [15:0]  ctrl2L_r;
    logic [15:0]  imask_r;
    logic [15:0]  status_r;
    logic [15:0]  regRdata_r;
    logic [15:0]  rdNxt;
    logic [15:0]  mclkLock;
    logic [15:0]  clrBits;
    logic [15:0]  setBits;
    logic         irq_r;

    logic portOn, stopIdle, sdoDis, word32, word16, sample_phase, cke, slave_select_enable, ckp, master, mclkSel;
    logic audio_mode_enable, framed_mode_enable, fsPw, dspMode, halted, run, ckeEff;

    assign portOn   = ctrl1L_r[BIT_PORT_ON];
    assign stopIdle = ctrl1L_r[BIT_STOP_IDLE];
    assign sdoDis   = ctrl1L_r[BIT_SDO_DIS];
    assign word32   = ctrl1L_r[BIT_WORD32];
    assign word16   = ctrl1L_r[BIT_WORD16];
    assign sample_phase      = ctrl1L_r[BIT_SMP];
    assign cke      = ctrl1L_r[BIT_CKE];
    assign slave_select_enable     = ctrl1L_r[BIT_SLAVE_SELECT_ENABLE];
    assign ckp      = ctrl1L_r[BIT_CKP];
    assign master   = ctrl1L_r[BIT_MASTER];
    assign mclkSel  = ctrl1L_r[BIT_MCLK_SEL];
    assign audio_mode_enable    = ctrl1H_r[BIT_AUDIO_MODE_ENABLE];
    assign framed_mode_enable    = ctrl1H_r[BIT_FRAMED_MODE_ENABLE];
    assign fsPw     = ctrl1H_r[BIT_FSPW];
    assign dspMode  = ctrl1H_r[BIT_DSP_MODE];

    assign halted = stopIdle & cpuIdle;
    assign run    = portOn & ~halted;
    assign ckeEff = cke & ~audio_mode_enable;

    logic [5:0] dataBits;
    logic [5:0] chanBits;
    logic [3:0] halfCyc;
    assign dataBits = spiev_data_bits(audio_mode_enable, word32, word16, ctrl2L_r[4:0]);
    assign chanBits = spiev_chan_bits(audio_mode_enable, word32, word16, dataBits);
    assign halfCyc  = mclkSel ? SCK_HALF_ALT_CYC : SCK_HALF_CYC;

    // ----------------------------------------------------------------
    // pin synchronisers and serial clock edges
    // ----------------------------------------------------------------
    logic [2:0] pinSync;
    logic       sckSync, sdiSync, ssnSync, sckPrev_r;
    logic       idleToActive, activeToIdle, chgEdgeS, sampleEdgeS, slaveSel;

    spiev_sync #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({sckIn, sdiIn, slaveSel_n}),
        .q       (pinSync)
    );
    assign sckSync = pinSync[2];
    assign sdiSync = pinSync[1];
    assign ssnSync = pinSync[0];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            sckPrev_r <= 1'b0;
        else
            sckPrev_r <= sckSync;
    end

    assign idleToActive = ckp ? (~sckSync & sckPrev_r) : (sckSync & ~sckPrev_r);
    assign activeToIdle = ckp ? (sckSync & ~sckPrev_r) : (~sckSync & sckPrev_r);
    assign chgEdgeS     = ckeEff ? activeToIdle : idleToActive;
    assign sampleEdgeS  = ckeEff ? idleToActive : activeToIdle;
    assign slaveSel     = framed_mode_enable | ~slave_select_enable | ~ssnSync;

    // ----------------------------------------------------------------
    // shift engine
    // ----------------------------------------------------------------
    spiev_state_t state_r;
    logic [31:0]  shTx_r;
    logic [31:0]  shRx_r;
    logic [31:0]  txBuf_r;
    logic [31:0]  rxBuf_r;
    logic [31:0]  rxNext;
    logic [31:0]  rxWord;
    logic [15:0]  txLo_r;
    logic [5:0]   bitsLeft_r;
    logic [4:0]   phase_r;
    logic [4:0]   phaseNxt;
    logic [4:0]   midPhase;
    logic [4:0]   lastPhase;
    logic         txFull_r, rxFull_r, skipChg_r, chanSel_r, sckOut_r, lrcOut_r;
    logic         stShift, stIdle, startM, startS, start, sampleM, bitEndM;
    logic         sampleNow, bitDone, wordDone, shiftOut, abortS, underrun, overflow;

    assign stShift   = (state_r == ST_SHIFT);
    assign stIdle    = (state_r == ST_IDLE);
    assign midPhase  = {1'b0, halfCyc};
    assign lastPhase = {halfCyc, 1'b0} - 5'h01;
    assign bitEndM   = (phase_r == lastPhase);
    assign sampleM   = sample_phase ? bitEndM : (phase_r == midPhase);

    assign startM    = stIdle & run & master & txFull_r;
    assign startS    = stIdle & run & ~master & slaveSel;
    assign start     = startM | startS;
    assign sampleNow = stShift & run & (master ? sampleM : (slaveSel & sampleEdgeS));
    assign bitDone   = stShift & run & (master ? bitEndM : (slaveSel & sampleEdgeS));
    assign wordDone  = bitDone & (bitsLeft_r == 6'h01);
    assign shiftOut  = stShift & run & (master ? bitEndM : (slaveSel & chgEdgeS & ~skipChg_r));
    assign abortS    = stShift & run & ~master & ~slaveSel;
    assign underrun  = startS & ~txFull_r;
    assign overflow  = wordDone & rxFull_r;
    assign rxNext    = sampleNow ? {shRx_r[30:0], sdiSync} : shRx_r;
    // audio data sits at the top of the channel, padding follows
    assign rxWord    = (rxNext >> (chanBits - dataBits)) & spiev_low_mask(dataBits);
    assign phaseNxt  = (startM | bitEndM) ? 5'h00 : phase_r + 5'h01;

    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
        begin
            state_r    <= ST_IDLE;
            shTx_r     <= 32'h0000_0000;
            shRx_r     <= 32'h0000_0000;
            bitsLeft_r <= 6'h00;
            phase_r    <= 5'h00;
            skipChg_r  <= 1'b0;
            chanSel_r  <= 1'b0;
        end
        else if (!halted)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    phase_r <= 5'h00;
                    if (start)
                    begin
                        state_r    <= ST_SHIFT;
                        shTx_r     <= txFull_r ? (txBuf_r << (LEN_32 - dataBits)) : 32'h0000_0000;
                        bitsLeft_r <= chanBits;
                        // with cke clear the first bit is already on the pin at the first edge
                        skipChg_r  <= ~ckeEff;
                    end
                end
                ST_SHIFT:
                begin
                    if (master)
                        phase_r <= phaseNxt;
                    if (sampleNow)
                        shRx_r <= rxNext;
                    if (shiftOut)
                        shTx_r <= {shTx_r[30:0], 1'b0};
                    if (chgEdgeS && slaveSel)
                        skipChg_r <= 1'b0;
                    if (bitDone)
                        bitsLeft_r <= bitsLeft_r - 6'h01;
                    if (wordDone && audio_mode_enable)
                        chanSel_r <= ~chanSel_r;
                    if (wordDone || abortS)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // master clock: idle level outside a word, stopped while off
    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
            sckOut_r <= 1'b0;
        else if (halted)
            sckOut_r <= sckOut_r;
        else if (startM || (stShift && master && !wordDone))
            sckOut_r <= ckp ^ (ckeEff ? (phaseNxt >= midPhase) : (phaseNxt < midPhase));
        else
            sckOut_r <= ckp;
    end

    // left/right clock; in dsp mode a pulse during the left channel word, first bit only or whole word per the pulse width setting
    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
            lrcOut_r <= 1'b0;
        else if (!audio_mode_enable)
            lrcOut_r <= 1'b0;
        else if (dspMode)
            lrcOut_r <= stShift & ~chanSel_r & (fsPw | (bitsLeft_r == chanBits));
        else
            lrcOut_r <= chanSel_r;
    end

    // ----------------------------------------------------------------
    // single-entry data buffers, depth independent of word length
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
        begin
            txLo_r   <= RESET_VALUE;
            txBuf_r  <= 32'h0000_0000;
            txFull_r <= 1'b0;
        end
        else
        begin
            if (regWr && regAddr == REG_DATA_LO)
                txLo_r <= regWdata;
            if (start && txFull_r)
                txFull_r <= 1'b0;
            else if (regWr && regAddr == REG_DATA_HI && !txFull_r)
            begin
                txBuf_r  <= {regWdata, txLo_r};
                txFull_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
        begin
            rxBuf_r  <= 32'h0000_0000;
            rxFull_r <= 1'b0;
        end
        else
        begin
            if (wordDone && !rxFull_r)
                rxBuf_r <= rxWord;
            rxFull_r <= (rxFull_r & ~(regRd && regAddr == REG_DATA_HI)) | (wordDone & ~rxFull_r);
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    assign mclkLock = portOn ? MCLK_MASK : RESET_VALUE;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl1L_r <= RESET_VALUE;
            ctrl1H_r <= RESET_VALUE;
            ctrl2L_r <= RESET_VALUE;
            imask_r  <= RESET_VALUE;
        end
        else if (regWr)
        begin
            case (regAddr)
                REG_CTRL1L: ctrl1L_r <= (regWdata & CTRL1L_WMASK & ~mclkLock) | (ctrl1L_r & mclkLock);
                REG_CTRL1H: ctrl1H_r <= regWdata & CTRL1H_WMASK;
                REG_CTRL2L: ctrl2L_r <= regWdata & CTRL2L_WMASK;
                REG_IMSKL:  imask_r  <= regWdata & EVT_MASK;
                default:    ctrl1L_r <= ctrl1L_r;
            endcase
        end
    end

    always_comb
    begin
        case (regAddr)
            REG_CTRL1L:  rdNxt = ctrl1L_r;
            REG_CTRL1H:  rdNxt = ctrl1H_r;
            REG_CTRL2L:  rdNxt = ctrl2L_r;
            REG_STATUS:  rdNxt = status_r;
            REG_IMSKL:   rdNxt = imask_r;
            REG_DATA_LO: rdNxt = rxBuf_r[15:0];
            REG_DATA_HI: rdNxt = rxBuf_r[31:16];
            default:     rdNxt = RESET_VALUE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            regRdata_r <= RESET_VALUE;
        else
            regRdata_r <= regRd ? rdNxt : RESET_VALUE;
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        setBits            = RESET_VALUE;
        setBits[EV_FRMERR] = abortS;
        setBits[EV_BUSY]   = stShift;
        setBits[EV_TUR]    = underrun;
        setBits[EV_SRMT]   = stIdle;
        setBits[EV_ROV]    = overflow;
        setBits[EV_RBE]    = ~rxFull_r;
        setBits[EV_TBE]    = ~txFull_r;
        setBits[EV_TBF]    = txFull_r;
        setBits[EV_RBF]    = rxFull_r;
    end

    assign clrBits = (regWr && regAddr == REG_STATUS) ? regWdata : RESET_VALUE;

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys)
    begin
        if (reset || !portOn)
            status_r <= RESET_VALUE;
        else
            status_r <= ((status_r & ~clrBits) | setBits) & EVT_MASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            irq_r <= 1'b0;
        else
            irq_r <= portOn & (|(status_r & imask_r & EVT_MASK));
    end

    assign regRdata = regRdata_r;
    assign sckOut   = sckOut_r;
    assign sckOe    = portOn & master;
    assign sdoOut   = shTx_r[31];
    assign sdoOe    = portOn & ~sdoDis;
    assign lrcOut   = lrcOut_r;
    assign lrcOe    = portOn & audio_mode_enable & master;
    assign irq      = irq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_mclk_write_lock: assert property (
        regWr && regAddr == REG_CTRL1L && portOn |=> ctrl1L_r[BIT_MCLK_SEL] == $past(ctrl1L_r[BIT_MCLK_SEL]))
        else $error("clock source select changed while port on");
    a_sdo_pin_release: assert property (
        $rose(ctrl1L_r[BIT_SDO_DIS]) |-> !sdoOe)
        else $error("data pin still driven after disable");
    a_len_byte_word: assert property (
        start && !audio_mode_enable && ctrl2L_r[4:0] == 5'h00 && !word32 && !word16 |=> bitsLeft_r == LEN_8)
        else $error("default word is not 8 bits");
    a_len_audio_24: assert property (
        start && audio_mode_enable && word32 && word16 |=> bitsLeft_r == LEN_32 && dataBits == LEN_24)
        else $error("audio 24-bit channel length wrong");
    a_len_audio_16: assert property (
        start && audio_mode_enable && !word32 && !word16 |=> bitsLeft_r == LEN_16)
        else $error("audio 16-bit channel length wrong");
    a_len_variable: assert property (
        start && !audio_mode_enable && ctrl2L_r[4:0] != 5'h00 |=> bitsLeft_r - 6'h01 == {1'b0, $past(ctrl2L_r[4:0])})
        else $error("variable word length wrong");
    a_sample_end_bit: assert property (
        stShift && run && master && sample_phase && bitEndM |=> shRx_r[0] == $past(sdiSync))
        else $error("master end sample missed");
    a_sample_mid_bit: assert property (
        stShift && run && master && !sample_phase && phase_r == midPhase |=> shRx_r[0] == $past(sdiSync))
        else $error("master middle sample missed");
    a_slave_mid_sample: assert property (
        stShift && run && !master && slaveSel && sampleEdgeS |=> shRx_r[0] == $past(sdiSync))
        else $error("slave sample missed");
    a_cke_idle_change: assert property (
        stShift && run && master && bitEndM && !wordDone && cke && !audio_mode_enable |=> sckOut_r == ckp)
        else $error("data change not on active to idle edge");
    a_audio_forces_cke: assert property (
        stShift && run && master && bitEndM && !wordDone && cke && audio_mode_enable |=> sckOut_r == !ckp)
        else $error("audio mode did not force cke low");
    a_busy_gated: assert property (
        status_r[EV_BUSY] && (status_r & imask_r) == RESET_VALUE |=> !irq)
        else $error("busy raised interrupt while disabled");
    a_event_gate: assert property (
        portOn && (|(status_r & imask_r)) |=> irq)
        else $error("enabled event did not raise interrupt");
    a_off_quiet: assert property (
        !portOn |=> status_r == RESET_VALUE && !irq && stIdle)
        else $error("port off but not quiet");
    a_idle_halt: assert property (
        halted && portOn && $stable(ctrl1L_r) |=> $stable(phase_r) && $stable(state_r))
        else $error("engine moved while halted");

    c_master_word: cover property (startM ##[1:800] wordDone && master);
    c_slave_word:  cover property (startS ##[1:800] wordDone && !master);
    c_overflow:    cover property (overflow);
    c_audio_frame: cover property (audio_mode_enable && wordDone && chanSel_r);

endmodule : spiev_port

// File: verification/spiev_far_slave.sv
`timescale 1ns/1ps
module spiev_far_slave
(
    input  wire logic        sck,
    input  wire logic        sdo,
    input  wire logic        load,
    input  wire logic [31:0] pat,
    output wire logic        sdi,
    output logic [31:0]      rxWord
);
    logic [5:0] cnt = 6'h00;
    // mode 1: new bit on each rising clock, master samples later
    always @(posedge sck or posedge load)
        if (load)
            cnt <= 6'h00;
        else
            cnt <= cnt + 6'h01;
    // before the frame the line shows the inverse, not a held value
    assign sdi = (cnt == 6'h00) ? ~pat[31] : pat[5'(6'd32 - cnt)];
    always @(negedge sck)
        rxWord <= {rxWord[30:0], sdo};
endmodule : spiev_far_slave

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench
    import spiev_pkg::*;
;
    localparam logic [31:0] PAT = 32'hC3A5_96E1;
    localparam logic [31:0] TXW = 32'h5A3C_0FF1;
    logic clk_sys = 0, reset = 1, regWr = 0, regRd = 0, load = 0;
    logic cpuIdle = 0, sckIn = 0, slaveSel_n = 1;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWdata = 16'h0000, d;
    wire logic [15:0] regRdata;
    wire logic sckOut, sdiIn, sdoOut, sdoOe, irq, sckOe, lrcOut, lrcOe;
    wire logic [31:0] rxWord;
    int fail_count = 0, samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    spiev_port spiev_port_i (.clk_sys(clk_sys), .reset(reset), .cpuIdle(cpuIdle), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sckIn(sckIn),
        .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiIn), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .slaveSel_n(slaveSel_n), .lrcOut(lrcOut), .lrcOe(lrcOe), .irq(irq));
    // the far side follows whichever end drives the link clock
    spiev_far_slave spiev_far_slave_i (.sck(sckOut | sckIn), .sdo(sdoOut), .load(load), .pat(PAT),
        .sdi(sdiIn), .rxWord(rxWord));
    // ----------------------------------------------------------------
    // register port access
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        regAddr <= a; regWdata <= v; regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            $display("Error %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // one word; the far side returns the top n bits of its pattern
    task automatic xfer(input logic [15:0] m, input logic [15:0] h, input logic [4:0] wl, input int n,
                        input logic be);
        logic [15:0] st, hi;
        logic [31:0] msk;
        logic        s;
        msk = 32'((64'h1 << n) - 64'h1);
        wr(REG_CTRL2L, {11'h000, wl});
        wr(REG_CTRL1H, h);
        wr(REG_CTRL1L, 16'h8000 | m);
        wr(REG_IMSKL, 16'(be) << EV_BUSY);
        wr(REG_STATUS, 16'hFFFF);
        settle();
        chk(irq, 0);
        chk(sckOe, m[BIT_MASTER]);
        chk(lrcOe, h[BIT_AUDIO_MODE_ENABLE] & m[BIT_MASTER]);
        load <= 1'b1;
        wr(REG_DATA_LO, TXW[15:0]);
        load <= 1'b0;
        wr(REG_DATA_HI, TXW[31:16]);
        // idle the cpu mid-word; the link clock must freeze
        if (m[BIT_STOP_IDLE])
        begin
            repeat (20) @(posedge clk_sys);
            cpuIdle <= 1'b1;
            @(posedge clk_sys);
            #1 s = sckOut;
            repeat (30)
            begin
                @(posedge clk_sys);
                #1 chk(sckOut, s);
            end
            @(posedge clk_sys);
            cpuIdle <= 1'b0;
        end
        // far master: select, then one 80 ns clock per bit
        if (!m[BIT_MASTER])
        begin
            slaveSel_n <= 1'b0;
            for (int i = 0; i < n; i++)
            begin
                repeat (5) @(posedge clk_sys);
                sckIn <= 1'b1;
                repeat (5) @(posedge clk_sys);
                sckIn <= 1'b0;
            end
            repeat (5) @(posedge clk_sys);
            slaveSel_n <= 1'b1;
        end
        st = 16'h0000;
        for (int i = 0; i < 300 && st[EV_RBF] !== 1'b1; i++)
            rd(REG_STATUS, st);
        chk(st[EV_RBF], 1);
        chk(irq, be);
        chk(lrcOut, h[BIT_AUDIO_MODE_ENABLE]);
        rd(REG_DATA_LO, d);
        rd(REG_DATA_HI, hi);
        chk({hi, d}, PAT >> (32 - n));
        chk(rxWord & msk, TXW & msk);
    endtask : xfer
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rd(REG_CTRL1L, d);
        chk(d, 0);
        wr(REG_CTRL1L, 16'h8020);
        wr(REG_CTRL1L, 16'h8024);
        rd(REG_CTRL1L, d);
        chk(d, 16'h8020);
        wr(REG_CTRL1L, 16'h0000);
        wr(REG_CTRL1L, 16'h0004);
        rd(REG_CTRL1L, d);
        chk(d, 16'h0004);
        wr(REG_CTRL1L, 16'h9020);
        settle();
        chk(sdoOe, 0);
        wr(REG_CTRL1L, 16'h8020);
        settle();
        chk(sdoOe, 1);
        wr(REG_IMSKL, 16'h0008);
        settle();
        chk(irq, 1);
        wr(REG_IMSKL, 16'h0000);
        settle();
        chk(irq, 0);
        wr(REG_IMSKL, 16'h0008);
        wr(REG_CTRL1L, 16'h0000);
        settle();
        chk(irq, 0);
        xfer(16'h0020, 16'h0000, 5'h00, 8, 1'b1);
        xfer(16'h0420, 16'h0000, 5'h00, 16, 1'b1);
        xfer(16'h0820, 16'h0000, 5'h00, 32, 1'b1);
        xfer(16'h2C20, 16'h0000, 5'h00, 32, 1'b1);
        xfer(16'h0020, 16'h0000, 5'h04, 5, 1'b0);
        xfer(16'h0220, 16'h0000, 5'h1F, 32, 1'b1);
        xfer(16'h0120, 16'h8000, 5'h04, 16, 1'b1);
        xfer(16'h0280, 16'h0000, 5'h00, 8, 1'b1);
        summarize();
    end
endmodule : testbench
